// >>> design/qrd_params.svh
`ifndef QRD_PARAMS_SVH
`define QRD_PARAMS_SVH

// Command codes of the two quad read commands
`define QRD_CMD_GENERAL   8'hEB
`define QRD_CMD_ALIGNED   8'hE7

// Continuation code of the mode field, overridable per instance
`define QRD_XIP_CODE      8'hA0

// Fields of the fifth status register
`define QRD_WA_BIT        0
`define QRD_DC_MSB        6
`define QRD_DC_LSB        4

// Link clock counts of each phase
`define QRD_CMD_CLKS      4'h8
`define QRD_ADDR_CLKS     4'h6
`define QRD_MODE_CLKS     4'h2

// Dummy clock counts per dummy_cycle_select code
`define QRD_DUMMY_000     4'h2
`define QRD_DUMMY_001     4'h4
`define QRD_DUMMY_010     4'h6
`define QRD_DUMMY_011     4'h8
`define QRD_DUMMY_100     4'hA

// Array geometry
`define QRD_ADDR_W        19
`define QRD_ADDR_LAST     19'h7FFFF
`define QRD_ADDR_FIRST    19'h00000

// Synchroniser reset value: chip select idle high, clock low
`define QRD_PINS_RST      6'h20

`endif

// >>> design/qrd_pkg.sv
`include "qrd_params.svh"

package qrd_pkg;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_CMD,
        ST_ADDR,
        ST_DUMMY,
        ST_DATA,
        ST_IGNORE
    } qrd_state_t;

    // Pin levels that cross into the clock domain together
    typedef struct packed {
        logic       cs_n;
        logic       sck;
        logic [3:0] io;
    } qrd_pins_t;

endpackage

// >>> design/qrd_array.sv
`timescale 1ns/10ps
`include "qrd_params.svh"

module qrd_array
    import qrd_pkg::*;
(
    input  wire logic                   i_clk,
    input  wire logic                   i_rstn,
    input  wire logic                   i_we,
    input  wire logic [`QRD_ADDR_W-1:0] i_waddr,
    input  wire logic [7:0]             i_wdata,
    input  wire logic [`QRD_ADDR_W-1:0] i_raddr,
    output logic      [7:0]             o_rdata
);

    logic [7:0] mem [0:(1<<`QRD_ADDR_W)-1];

    ////////////////////////////////////////////////////////////////////////
    // Preload port, no reset on the array itself
    always_ff @(posedge i_clk) begin
        if (i_we) begin
            mem[i_waddr] <= i_wdata;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // One cycle read; the link is far slower than this latency
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_rdata <= 8'h00;
        end else begin
            o_rdata <= mem[i_raddr];
        end
    end

endmodule

// >>> design/qrd_quad_read.sv
// Function
// - Command byte MSB first; decode EBh, E7h
// - Address four bits per clock, six clocks
// - Aligned command forces address bits 1:0 zero
// - General command alignment from word_align_select
// - Capture 8-bit mode field after address
// - Continuous mode: transfer starts with address
// - Dummy count from dummy_cycle_select, includes mode
// - Codes 000..100 give 2,4,6,8,10 clocks
// - Aligned command ignores word_align_select
// - After dummies all four lines drive
// - Byte out high nibble first, IO3 MSB
// - Chip select release ends read, lines float
// - Address wraps from 07FFFFh to zero
// - No enable command needed before reading
`timescale 1ns/10ps
`include "qrd_params.svh"

module qrd_quad_read
    import qrd_pkg::*;
#(
    parameter logic [7:0] XIP_CODE = `QRD_XIP_CODE
) (
    input  wire logic                   i_clk,
    input  wire logic                   i_rstn,
    input  wire logic                   i_cs_n,
    input  wire logic                   i_sck,
    input  wire logic [3:0]             i_io,
    output logic      [3:0]             o_io_out,
    output logic      [3:0]             o_io_oe,
    input  wire logic [7:0]             i_fifth_status_register,
    output logic                        o_execute_in_place,
    input  wire logic                   i_load_we,
    input  wire logic [`QRD_ADDR_W-1:0] i_load_addr,
    input  wire logic [7:0]             i_load_data
);

    qrd_pins_t              pins_m;
    qrd_pins_t              pins_s;
    logic                   sck_d;
    logic                   rise;
    logic                   fall;
    logic                   cs_act;
    qrd_state_t             state;
    logic [3:0]             cnt;
    logic                   phase_end;
    logic [7:0]             cmd;
    logic [7:0]             next_cmd;
    logic                   aligned_cmd;
    logic [15:0]            addr_sr;
    logic [`QRD_ADDR_W-1:0] next_addr;
    logic [`QRD_ADDR_W-1:0] addr;
    logic [7:0]             mode;
    logic [7:0]             next_mode;
    logic                   execute_in_place;
    logic                   half;
    logic                   io_oe;
    logic [3:0]             io_out;
    logic [7:0]             rd_data;
    logic [3:0]             rd_hi;
    logic [3:0]             rd_lo;
    logic [2:0]             dc;
    logic                   wa;
    logic [3:0]             ndum;

    ////////////////////////////////////////////////////////////////////////
    // Helpers

    function automatic logic [3:0] qrd_dummy_clks(input logic [2:0] sel);
        case (sel)
            3'h0:    return `QRD_DUMMY_000;
            3'h1:    return `QRD_DUMMY_001;
            3'h2:    return `QRD_DUMMY_010;
            3'h3:    return `QRD_DUMMY_011;
            // Reserved codes fall back to the longest, safest setting
            default: return `QRD_DUMMY_100;
        endcase
    endfunction

    function automatic logic qrd_is_quad(input logic [7:0] code);
        return (code == `QRD_CMD_GENERAL) || (code == `QRD_CMD_ALIGNED);
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Pin synchroniser and link clock edges

    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            pins_m <= `QRD_PINS_RST;
            pins_s <= `QRD_PINS_RST;
            sck_d  <= 1'b0;
        end else begin
            pins_m <= '{cs_n: i_cs_n, sck: i_sck, io: i_io};
            pins_s <= pins_m;
            sck_d  <= pins_s.sck;
        end
    end

    assign rise   = pins_s.sck & ~sck_d;
    assign fall   = ~pins_s.sck & sck_d;
    assign cs_act = ~pins_s.cs_n;

    ////////////////////////////////////////////////////////////////////////
    // Configuration fields

    assign dc   = i_fifth_status_register[`QRD_DC_MSB:`QRD_DC_LSB];
    assign wa   = i_fifth_status_register[`QRD_WA_BIT];
    assign ndum = qrd_dummy_clks(dc);

    assign next_cmd  = {cmd[6:0], pins_s.io[0]};
    assign next_mode = {mode[3:0], pins_s.io};

    always_comb begin
        next_addr = {addr_sr[`QRD_ADDR_W-5:0], pins_s.io};
        // Aligned command overrides the select bit
        if (aligned_cmd || wa) begin
            next_addr[1:0] = 2'b00;
        end
    end

    always_comb begin
        case (state)
            ST_CMD:   phase_end = rise && (cnt == `QRD_CMD_CLKS - 4'h1);
            ST_ADDR:  phase_end = rise && (cnt == `QRD_ADDR_CLKS - 4'h1);
            ST_DUMMY: phase_end = rise && (cnt == ndum - 4'h1);
            default:  phase_end = 1'b0;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // Transfer sequencer

    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            state <= ST_IDLE;
        end else if (!cs_act) begin
            state <= ST_IDLE;
        end else begin
            case (state)
                // Frame start; continuous mode skips the command byte
                ST_IDLE: begin
                    state <= execute_in_place ? ST_ADDR : ST_CMD;
                end
                // No write enable or other state is consulted
                ST_CMD: begin
                    if (phase_end) begin
                        state <= qrd_is_quad(next_cmd) ? ST_ADDR : ST_IGNORE;
                    end
                end
                ST_ADDR: begin
                    if (phase_end) begin
                        state <= ST_DUMMY;
                    end
                end
                ST_DUMMY: begin
                    if (phase_end) begin
                        state <= ST_DATA;
                    end
                end
                ST_DATA:   state <= ST_DATA;
                ST_IGNORE: state <= ST_IGNORE;
                default:   state <= ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            cnt <= 4'h0;
        end else if (!cs_act || state == ST_IDLE) begin
            cnt <= 4'h0;
        end else if (phase_end) begin
            cnt <= 4'h0;
        end else if (rise && (state == ST_CMD || state == ST_ADDR || state == ST_DUMMY)) begin
            cnt <= cnt + 4'h1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Command capture

    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            cmd <= 8'h00;
        end else if (rise && state == ST_CMD) begin
            cmd <= next_cmd;
        end
    end

    // Held across continuous transfers, which carry no command
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            aligned_cmd <= 1'b0;
        end else if (phase_end && state == ST_CMD && qrd_is_quad(next_cmd)) begin
            aligned_cmd <= (next_cmd == `QRD_CMD_ALIGNED);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Address capture and read pointer

    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            addr_sr <= 16'h0000;
        end else if (rise && state == ST_ADDR) begin
            // Four nibbles kept so A18:A16 survive until the last nibble
            addr_sr <= {addr_sr[11:0], pins_s.io};
        end
    end

    // Upper address bits beyond the array are dropped, so any start wraps
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            addr <= `QRD_ADDR_FIRST;
        end else if (phase_end && state == ST_ADDR) begin
            addr <= next_addr;
        end else if (cs_act && state == ST_DATA && fall && half) begin
            addr <= addr + 19'h00001;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Mode field and continuous mode

    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            mode <= 8'h00;
        end else if (rise && state == ST_DUMMY && cnt < `QRD_MODE_CLKS) begin
            mode <= next_mode;
        end
    end

    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            execute_in_place <= 1'b0;
        end else if (cs_act && rise && state == ST_DUMMY
                     && cnt == `QRD_MODE_CLKS - 4'h1) begin
            execute_in_place <= (next_mode == XIP_CODE);
        end
    end

    assign o_execute_in_place = execute_in_place;

    ////////////////////////////////////////////////////////////////////////
    // Data drive, changed on falling link clock edges

    assign rd_hi = rd_data[7:4];
    assign rd_lo = rd_data[3:0];

    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            io_oe  <= 1'b0;
            io_out <= 4'h0;
            half   <= 1'b0;
        end else if (!cs_act || state != ST_DATA) begin
            io_oe <= 1'b0;
            half  <= 1'b0;
        end else if (fall) begin
            io_oe  <= 1'b1;
            io_out <= half ? rd_lo : rd_hi;
            half   <= ~half;
        end
    end

    assign o_io_out = io_out;
    assign o_io_oe  = {4{io_oe}};

    qrd_array u_array (
        .i_clk   (i_clk),
        .i_rstn  (i_rstn),
        .i_we    (i_load_we),
        .i_waddr (i_load_addr),
        .i_wdata (i_load_data),
        .i_raddr (addr),
        .o_rdata (rd_data)
    );

    ////////////////////////////////////////////////////////////////////////
    // Checks

    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rstn);

    sequence s_cmd_last;
        cs_act && state == ST_CMD && rise && cnt == 4'h7;
    endsequence

    sequence s_addr_last;
        cs_act && state == ST_ADDR && rise && cnt == 4'h5;
    endsequence

    sequence s_mode_last;
        cs_act && state == ST_DUMMY && rise && cnt == 4'h1;
    endsequence

    a_cmd_decode: assert property (
        s_cmd_last ##0 qrd_is_quad(next_cmd) |=> state == ST_ADDR)
        else $error("quad command not followed by address");

    a_cmd_reject: assert property (
        s_cmd_last ##0 !qrd_is_quad(next_cmd) |=> state == ST_IGNORE)
        else $error("foreign command not ignored");

    a_addr_len: assert property (
        s_addr_last |=> state == ST_DUMMY && cnt == 4'h0)
        else $error("address phase not six clocks");

    a_align_low: assert property (
        s_addr_last ##0 (aligned_cmd || wa) |=> addr[1:0] == 2'b00)
        else $error("aligned start address has low bits set");

    a_mode_decide: assert property (
        s_mode_last |=> execute_in_place == (mode == XIP_CODE))
        else $error("continuous mode not taken from mode field");

    a_xip_skip: assert property (
        (state == ST_IDLE && cs_act && execute_in_place) |=> state == ST_ADDR)
        else $error("continuous transfer expected command byte");

    a_dummy_hold: assert property (
        (cs_act && state == ST_DUMMY && rise && cnt < ndum - 4'h1)
        |=> state == ST_DUMMY)
        else $error("dummy phase ended early");

    a_dummy_end: assert property (
        (cs_act && state == ST_DUMMY && rise && dc <= 3'h4 && cnt == {dc, 1'b1})
        |=> state == ST_DATA)
        else $error("dummy phase overran");

    a_oe_data: assert property (
        o_io_oe != 4'h0 |-> $past(state) == ST_DATA)
        else $error("lines driven outside data phase");

    a_nibble_order: assert property (
        (cs_act && state == ST_DATA && fall && !half)
        |=> o_io_out == $past(rd_hi) && o_io_oe == 4'hF ##1 half)
        else $error("high nibble not driven first");

    a_cs_release: assert property (
        !cs_act |=> o_io_oe == 4'h0 && state == ST_IDLE)
        else $error("lines still driven after chip select release");

    a_addr_wrap: assert property (
        (cs_act && state == ST_DATA && fall && half && addr == `QRD_ADDR_LAST)
        |=> addr == `QRD_ADDR_FIRST)
        else $error("address did not wrap to zero");

endmodule

// >>> bench/qrd_host.sv
`timescale 1ns/10ps

module qrd_host (
    input  wire logic       i_clk,
    input  wire logic [3:0] i_io,
    output logic            o_cs_n,
    output logic            o_sck,
    output logic [3:0]      o_io
);

    initial begin
        o_cs_n = 1'b1;
        o_sck  = 1'b0;
        o_io   = 4'hF;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // One link clock of 160 ns, mode 0: lines change while low, both sides sample on rise
    task automatic tick(input logic [3:0] v, output logic [3:0] s);
        o_io = v;
        repeat (10) @(posedge i_clk);
        #1 o_sck = 1'b1;
        s = i_io;
        repeat (10) @(posedge i_clk);
        #1 o_sck = 1'b0;
    endtask

    // Whole frame; a trailing half byte is dropped as the device drops it
    task automatic frame(input logic c_on, input logic [7:0] c, input logic [23:0] a,
                         input logic [7:0] m, input int nd, input int nnib,
                         output logic [7:0] rd[$]);
        logic [3:0] s;
        logic [3:0] hi;
        rd = {};
        @(posedge i_clk);
        #1 o_cs_n = 1'b0;
        if (c_on) for (int i = 7; i >= 0; i--) tick({3'b111, c[i]}, s);
        for (int i = 5; i >= 0; i--) tick(a[i*4+:4], s);
        tick(m[7:4], s);
        tick(m[3:0], s);
        for (int i = 2; i < nd; i++) tick(4'(i), s);
        for (int i = 0; i < nnib; i++) begin
            // Released lines show the inverse of the last level, never a held copy
            tick(~s, s);
            if (i % 2 == 1) rd.push_back({hi, s});
            hi = s;
        end
        o_cs_n = 1'b1;
        o_io = 4'hF;
        repeat (4) @(posedge i_clk);
        #1;
    endtask

endmodule

// >>> bench/tb_qrd_quad_read.sv
`timescale 1ns/10ps
`include "qrd_params.svh"

module tb_qrd_quad_read;

    logic        i_clk;
    logic        i_rstn;
    logic        load_we;
    logic [18:0] load_addr;
    logic [7:0]  load_data;
    logic [7:0]  fsr;
    logic        cs_n;
    logic        sck;
    logic [3:0]  host_io;
    logic [3:0]  io_out;
    logic [3:0]  io_oe;
    logic [3:0]  io_wire;
    logic        execute_in_place;
    int          oe_cnt = 0;
    int          error_cnt;
    int          n_checks;
    logic [18:0] bases [6] = '{19'h00000, 19'h00100, 19'h00200, 19'h00300, 19'h00400,
                               19'h7FFF0};

    qrd_quad_read #(
        .XIP_CODE (`QRD_XIP_CODE)
    ) u_qrd_quad_read (
        .i_clk                   (i_clk),
        .i_rstn                  (i_rstn),
        .i_cs_n                  (cs_n),
        .i_sck                   (sck),
        .i_io                    (io_wire),
        .o_io_out                (io_out),
        .o_io_oe                 (io_oe),
        .i_fifth_status_register (fsr),
        .o_execute_in_place      (execute_in_place),
        .i_load_we               (load_we),
        .i_load_addr             (load_addr),
        .i_load_data             (load_data)
    );

    qrd_host u_qrd_host (
        .i_clk  (i_clk),
        .i_io   (io_wire),
        .o_cs_n (cs_n),
        .o_sck  (sck),
        .o_io   (host_io)
    );

    always #4 i_clk = ~i_clk;

    assign io_wire = (io_oe & io_out) | (~io_oe & host_io);

    always @(posedge i_clk) begin
        if (io_oe !== 4'h0) oe_cnt <= oe_cnt + 1;
    end

    ////////////////////////////////////////////////////////////////////////////////
    function automatic logic [7:0] pat(input logic [18:0] a);
        return a[7:0] ^ {a[18:16], a[12:8]} ^ 8'h3C;
    endfunction

    task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
        n_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic load(input logic [18:0] a);
        @(posedge i_clk);
        #1 load_we = 1'b1;
        load_addr = a;
        load_data = pat(a);
        @(posedge i_clk);
        #1 load_we = 1'b0;
    endtask

    task automatic rd_chk(input logic c_on, input logic [7:0] c, input logic [23:0] a,
                          input logic [7:0] m, input int nd, input int nnib,
                          input logic [18:0] exp_a);
        logic [7:0] rd[$];
        u_qrd_host.frame(c_on, c, a, m, nd, nnib, rd);
        chk("bytes", 8'(rd.size()), 8'(nnib / 2));
        foreach (rd[k]) chk("data", rd[k], pat(exp_a + 19'(k)));
        chk("oe_after", {4'h0, io_oe}, 8'h00);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_general();
        fsr = 8'h00;
        rd_chk(1'b1, `QRD_CMD_GENERAL, 24'h000101, 8'h00, 2, 6,
               19'h00101);
        chk("xip", {7'h0, execute_in_place}, 8'h00);
    endtask

    task automatic t_dummy();
        // Code 101 is reserved and runs as the longest setting
        for (int dc = 0; dc < 6; dc++) begin
            fsr = {1'b0, 3'(dc), 4'h1};
            rd_chk(1'b1, `QRD_CMD_GENERAL, 24'hF00203, 8'hFF, (dc > 4) ? 10 : 2 * dc + 2, 4,
                   19'h00200);
        end
    endtask

    task automatic t_aligned();
        fsr = 8'h30;
        rd_chk(1'b1, `QRD_CMD_ALIGNED, 24'h000307, 8'h00, 8, 4, 19'h00304);
    endtask

    task automatic t_xip();
        fsr = 8'h10;
        rd_chk(1'b1, `QRD_CMD_GENERAL, 24'h000401, `QRD_XIP_CODE, 4, 4, 19'h00401);
        chk("xip_on", {7'h0, execute_in_place}, 8'h01);
        rd_chk(1'b0, 8'h00, 24'h000408, `QRD_XIP_CODE, 4, 4, 19'h00408);
        chk("xip_hold", {7'h0, execute_in_place}, 8'h01);
        rd_chk(1'b0, 8'h00, 24'h00040C, 8'h5A, 4, 2, 19'h0040C);
        chk("xip_off", {7'h0, execute_in_place}, 8'h00);
        rd_chk(1'b1, `QRD_CMD_ALIGNED, 24'h000402, 8'h00, 4, 2, 19'h00400);
    endtask

    task automatic t_wrap();
        fsr = 8'h40;
        rd_chk(1'b1, `QRD_CMD_GENERAL, 24'h07FFFF, 8'h00, 10, 6, 19'h7FFFF);
    endtask

    task automatic t_abort();
        int oe_base;
        fsr = 8'h00;
        // Three nibbles: the half byte must vanish and the lines float
        rd_chk(1'b1, `QRD_CMD_GENERAL, 24'h000103, 8'h00, 2, 3, 19'h00103);
        oe_base = oe_cnt;
        rd_chk(1'b1, 8'h03, 24'h000100, 8'h00, 2, 0, 19'h00000);
        chk("oe_refused", 8'(oe_cnt - oe_base), 8'h00);
    endtask

    task automatic end_sim();
        if (error_cnt == 0 && n_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        i_clk = 1'b0;
        i_rstn = 1'b0;
        load_we = 1'b0;
        load_addr = 19'h00000;
        load_data = 8'h00;
        fsr = 8'h00;
        error_cnt = 0;
        n_checks = 0;
        repeat (6) @(posedge i_clk);
        #1 i_rstn = 1'b1;
        foreach (bases[b]) for (int k = 0; k < 16; k++) load(bases[b] + 19'(k));
        t_general();
        t_dummy();
        t_aligned();
        t_xip();
        t_wrap();
        t_abort();
        end_sim();
    end

    // About 15 frames, some 55 us in all; limit kept near 25k cycles
    initial begin
        #200000;
        error_cnt++;
        end_sim();
    end

endmodule
